/* dcp_debug_command_port.sv */
// Purpose: Stuff and execute commands of the on-chip debugger.
// Assumes: Received bytes arrive as one-cycle strobes on CLK.
// Notes:   Other command codes are left to neighbouring logic.
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none

module dcp_debug_command_port
   import dcp_pkg::*;
(
   // Clock and reset
   input  wire logic                  CLK,
   input  wire logic                  RESETN,
   // Register port
   input  wire logic [DCP_ADDR_W-1:0] ADDR,
   input  wire logic [7:0]            WDATA,
   input  wire logic                  WR,
   input  wire logic                  RD,
   output logic      [7:0]            RDATA,
   // Bytes from the debug serial pin
   input  wire logic                  RX_VALID,
   input  wire logic [7:0]            RX_DATA,
   // Flash option
   input  wire logic                  READ_PROTECT,
   // Debugger state
   output logic                       DEBUG_HALT,
   output logic                       BREAKPOINT_ENABLE,
   output logic                       DEVICE_RESET,
   // Stuffed instruction to the CPU
   output logic                       STUFF_VALID,
   output logic      [7:0]            STUFF_OPCODE,
   output logic      [2:0]            STUFF_FETCH_COUNT,
   // Executed instruction to the CPU
   output logic                       EXEC_VALID,
   output logic      [2:0]            EXEC_LENGTH,
   output logic      [39:0]           EXEC_BYTES
);

   typedef struct packed {
      dcp_state_type                       state;
      logic [2:0]                          idx;
      logic [2:0]                          len;
      logic [DCP_MAX_BYTES-1:0][7:0]       bytes;
      logic                                stuff_valid;
      logic [7:0]                          stuff_op;
      logic [2:0]                          stuff_fetch;
      logic                                exec_valid;
      logic [2:0]                          exec_len;
   } dcp_port_state_type;

   dcp_port_state_type s;
   dcp_port_state_type next_s;

   logic       halted;
   logic       brk_enable;
   logic       reset_pulse;
   logic       ctrl_write;
   logic       busy;
   logic       allowed;

   // ------------------------------------------------------------
   // Control and status registers
   // ------------------------------------------------------------
   dcp_regs u_regs (
      .clk         (CLK),
      .resetn      (RESETN),
      .addr        (ADDR),
      .wdata       (WDATA),
      .wr          (WR),
      .rd          (RD),
      .rdata       (RDATA),
      .busy        (busy),
      .protect     (READ_PROTECT),
      .halted      (halted),
      .brk_enable  (brk_enable),
      .reset_pulse (reset_pulse),
      .ctrl_write  (ctrl_write)
   );

   assign busy    = (s.state != DCP_IDLE);
   assign allowed = halted && !READ_PROTECT;

   // ------------------------------------------------------------
   // Command sequencer
   // ------------------------------------------------------------
   always_comb begin
      next_s             = s;
      next_s.stuff_valid = 1'b0;
      next_s.exec_valid  = 1'b0;
      case (s.state)
         DCP_IDLE: begin
            if (RX_VALID) begin
               if (RX_DATA == DCP_CMD_STUFF && allowed) begin
                  next_s.state = DCP_STUFF_OPCODE;
               end else if (RX_DATA == DCP_CMD_EXECUTE) begin
                  next_s.state = allowed ? DCP_EXEC_FIRST : DCP_DISCARD;
               end
               // Stuff while not allowed leaves no trace at all
            end
         end
         DCP_STUFF_OPCODE: begin
            if (RX_VALID) begin
               next_s.stuff_valid = 1'b1;
               next_s.stuff_op    = RX_DATA;
               next_s.stuff_fetch = dcp_instr_len(RX_DATA) - DCP_LEN_ONE;
               next_s.state       = DCP_IDLE;
            end
         end
         DCP_EXEC_FIRST: begin
            if (RX_VALID) begin
               next_s.bytes    = '0;
               next_s.bytes[0] = RX_DATA;
               next_s.len      = dcp_instr_len(RX_DATA);
               next_s.idx      = 3'd1;
               if (dcp_instr_len(RX_DATA) == DCP_LEN_ONE) begin
                  next_s.exec_valid = 1'b1;
                  next_s.exec_len   = DCP_LEN_ONE;
                  next_s.state      = DCP_IDLE;
               end else begin
                  next_s.state = DCP_EXEC_REST;
               end
            end
         end
         DCP_EXEC_REST: begin
            if (RX_VALID) begin
               next_s.bytes[s.idx] = RX_DATA;
               next_s.idx          = s.idx + 3'd1;
               if (s.idx + 3'd1 == s.len) begin
                  next_s.exec_valid = 1'b1;
                  next_s.exec_len   = s.len;
                  next_s.state      = DCP_IDLE;
               end
            end
         end
         DCP_DISCARD: begin
            // One byte swallowed, nothing runs
            if (RX_VALID) begin
               next_s.state = DCP_IDLE;
            end
         end
         default: next_s.state = DCP_IDLE;
      endcase
      // A device reset abandons any half-received command
      if (ctrl_write && reset_pulse) begin
         next_s.state = DCP_IDLE;
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         s <= '{state: DCP_IDLE, default: '0};
      end else begin
         s <= next_s;
      end
   end

   // ------------------------------------------------------------
   // Outputs, all from flip-flops
   // ------------------------------------------------------------
   assign DEBUG_HALT        = halted;
   assign BREAKPOINT_ENABLE = brk_enable;
   assign DEVICE_RESET      = reset_pulse;
   assign STUFF_VALID       = s.stuff_valid;
   assign STUFF_OPCODE      = s.stuff_op;
   assign STUFF_FETCH_COUNT = s.stuff_fetch;
   assign EXEC_VALID        = s.exec_valid;
   assign EXEC_LENGTH       = s.exec_len;
   assign EXEC_BYTES        = s.bytes;

endmodule

`default_nettype wire

/* dcp_pkg.sv */
// Purpose: Constants and types shared by the debug command port.
// Assumes: Bytes from the debug serial pin are already deserialised.
// Notes:   Instruction length table lives here so both users agree.
package dcp_pkg;

   // ------------------------------------------------------------
   // Debug command codes
   // ------------------------------------------------------------
   localparam logic [7:0] DCP_CMD_STUFF   = 8'h11;
   localparam logic [7:0] DCP_CMD_EXECUTE = 8'h12;

   // ------------------------------------------------------------
   // Register port
   // ------------------------------------------------------------
   localparam int         DCP_ADDR_W       = 4;
   localparam logic [3:0] DCP_OFS_CONTROL  = 4'h0;
   localparam logic [3:0] DCP_OFS_STATUS   = 4'h1;
   localparam logic [7:0] DCP_CONTROL_RST  = 8'h00;
   localparam logic [7:0] DCP_RDATA_NONE   = 8'h00;

   // Control register fields
   localparam int DCP_CTL_DEBUG_BIT = 7;
   localparam int DCP_CTL_BRK_BIT   = 6;
   localparam int DCP_CTL_RESET_BIT = 0;

   // Control values with a defined meaning
   localparam logic [7:0] DCP_CTL_RESET_STOP = 8'h81;
   localparam logic [7:0] DCP_CTL_RESET_GO   = 8'h41;
   localparam logic [7:0] DCP_CTL_RUN        = 8'h40;

   // Status register fields
   localparam int DCP_STS_DEBUG_BIT   = 7;
   localparam int DCP_STS_BRK_BIT     = 6;
   localparam int DCP_STS_PROTECT_BIT = 1;
   localparam int DCP_STS_BUSY_BIT    = 0;

   // ------------------------------------------------------------
   // Instruction sizes
   // ------------------------------------------------------------
   localparam int         DCP_MAX_BYTES = 5;
   localparam logic [2:0] DCP_LEN_ONE   = 3'd1;

   typedef enum {
      DCP_IDLE,
      DCP_STUFF_OPCODE,
      DCP_EXEC_FIRST,
      DCP_EXEC_REST,
      DCP_DISCARD
   } dcp_state_type;

   // Total byte count of an instruction, decoded from its opcode
   function automatic logic [2:0] dcp_instr_len(input logic [7:0] opcode);
      logic [2:0] len;
      len = 3'd2;
      case (opcode[3:0])
         4'h0, 4'h1, 4'h2, 4'h3:       len = 3'd2;
         4'h4, 4'h5, 4'h6, 4'h7:       len = 3'd3;
         4'h8, 4'h9: begin
            if (opcode[7:4] == 4'he || opcode[7:4] == 4'hf) begin
               len = 3'd5;
            end else if (opcode[7:4] == 4'hc || opcode[7:4] == 4'hd) begin
               len = 3'd4;
            end else begin
               len = 3'd3;
            end
         end
         4'ha, 4'hb, 4'hc:             len = 3'd2;
         4'hd:                         len = 3'd3;
         4'he, 4'hf:                   len = 3'd1;
         default:                      len = 3'd2;
      endcase
      return len;
   endfunction

endpackage

/* dcp_regs.sv */
// Purpose: Debugger control and status registers on the plain port.
// Assumes: One strobe per cycle; read data valid the cycle after.
// Notes:   Reset request is a one-cycle pulse to the reset logic.
`timescale 1ns/10ps
`default_nettype none

module dcp_regs
   import dcp_pkg::*;
(
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  resetn,
   // Register port
   input  wire logic [DCP_ADDR_W-1:0] addr,
   input  wire logic [7:0]            wdata,
   input  wire logic                  wr,
   input  wire logic                  rd,
   output logic      [7:0]            rdata,
   // Block state
   input  wire logic                  busy,
   input  wire logic                  protect,
   output logic                       halted,
   output logic                       brk_enable,
   output logic                       reset_pulse,
   output logic                       ctrl_write
);

   typedef struct packed {
      logic [7:0] rdata;
      logic       halted;
      logic       breakpoint_instruction;
      logic       rst;
      logic       wr_ctl;
   } dcp_regs_state_type;

   dcp_regs_state_type r;
   dcp_regs_state_type next_r;

   always_comb begin
      next_r        = r;
      next_r.rst    = 1'b0;
      next_r.wr_ctl = 1'b0;
      next_r.rdata  = DCP_RDATA_NONE;
      if (wr && addr == DCP_OFS_CONTROL) begin
         // Debug entry and exit, breakpoint enable, device reset
         next_r.halted = wdata[DCP_CTL_DEBUG_BIT];
         next_r.breakpoint_instruction    = wdata[DCP_CTL_BRK_BIT];
         next_r.rst    = wdata[DCP_CTL_RESET_BIT];
         next_r.wr_ctl = 1'b1;
      end
      if (rd) begin
         case (addr)
            DCP_OFS_CONTROL: begin
               next_r.rdata[DCP_CTL_DEBUG_BIT] = r.halted;
               next_r.rdata[DCP_CTL_BRK_BIT]   = r.breakpoint_instruction;
            end
            DCP_OFS_STATUS: begin
               next_r.rdata[DCP_STS_DEBUG_BIT]   = r.halted;
               next_r.rdata[DCP_STS_BRK_BIT]     = r.breakpoint_instruction;
               next_r.rdata[DCP_STS_PROTECT_BIT] = protect;
               next_r.rdata[DCP_STS_BUSY_BIT]    = busy;
            end
            default: next_r.rdata = DCP_RDATA_NONE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign rdata       = r.rdata;
   assign halted      = r.halted;
   assign brk_enable  = r.breakpoint_instruction;
   assign reset_pulse = r.rst;
   assign ctrl_write  = r.wr_ctl;

endmodule

`default_nettype wire

/* dcp_props.sv */
// Purpose: Assertions on the debug command port pins.
// Assumes: Bound to the top module, one clock domain.
// Notes:   Permission is judged at the edge taking the code.
`timescale 1ns/10ps
`default_nettype none
module dcp_props
   import dcp_pkg::*;
(
   // Clock, reset and register port
   input wire logic        CLK,
   input wire logic        RESETN,
   input wire logic [3:0]  ADDR,
   input wire logic [7:0]  WDATA,
   input wire logic        WR,
   // Link, option and results
   input wire logic        RX_VALID,
   input wire logic [7:0]  RX_DATA,
   input wire logic        READ_PROTECT,
   input wire logic        DEBUG_HALT,
   input wire logic        BREAKPOINT_ENABLE,
   input wire logic        DEVICE_RESET,
   input wire logic        STUFF_VALID,
   input wire logic [7:0]  STUFF_OPCODE,
   input wire logic [2:0]  STUFF_FETCH_COUNT,
   input wire logic        EXEC_VALID,
   input wire logic [2:0]  EXEC_LENGTH,
   input wire logic [39:0] EXEC_BYTES
);
   // ----------
   // Properties
   // ----------
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESETN);
   logic ctl_wr;
   assign ctl_wr = WR && ADDR == DCP_OFS_CONTROL;

   stuff_data_a: assert property (STUFF_VALID |-> $past(RX_VALID) && STUFF_OPCODE == $past(RX_DATA))
      else $error("stuffed opcode not the last byte");
   stuff_perm_a: assert property (STUFF_VALID |-> $past(DEBUG_HALT, 2) && !$past(READ_PROTECT, 2))
      else $error("stuff taken without permission");
   stuff_count_a: assert property (STUFF_VALID |-> STUFF_FETCH_COUNT <= 3'd4)
      else $error("fetch count above four");
   exec_src_a: assert property (EXEC_VALID |-> EXEC_LENGTH inside {[3'd1:3'd5]} &&
      $past(RX_VALID) && EXEC_BYTES[8*EXEC_LENGTH-1 -: 8] == $past(RX_DATA)) else $error("bad instruction");
   stop_write_a: assert property (ctl_wr && WDATA == DCP_CTL_RESET_STOP |=>
      DEVICE_RESET && DEBUG_HALT ##1 !DEVICE_RESET) else $error("reset and stop");
   go_write_a: assert property (ctl_wr && WDATA == DCP_CTL_RESET_GO |=>
      DEVICE_RESET && !DEBUG_HALT && BREAKPOINT_ENABLE) else $error("reset and go");
   run_write_a: assert property (ctl_wr && WDATA == DCP_CTL_RUN |=>
      !DEBUG_HALT && !DEVICE_RESET) else $error("run");
   reset_cause_a: assert property ($rose(DEVICE_RESET) |-> $past(ctl_wr) && $past(WDATA[0]))
      else $error("reset without control write");
endmodule

bind dcp_debug_command_port dcp_props chk (.CLK, .RESETN, .ADDR, .WDATA, .WR, .RX_VALID, .RX_DATA,
   .READ_PROTECT, .DEBUG_HALT, .BREAKPOINT_ENABLE, .DEVICE_RESET, .STUFF_VALID, .STUFF_OPCODE,
   .STUFF_FETCH_COUNT, .EXEC_VALID, .EXEC_LENGTH, .EXEC_BYTES);
`default_nettype wire

/* dcp_host.sv */
// Purpose: Debug host model handing received bytes over.
// Assumes: Bytes are already deserialised, one per strobe.
// Notes:   Idle data is inverted so a stale byte never matches.
`timescale 1ns/10ps
`default_nettype none
module dcp_host (
   // Byte link
   input  wire logic       clk,
   output logic            rx_valid,
   output logic      [7:0] rx_data
);
   // -----
   // Tasks
   // -----
   initial begin
      rx_valid = 1'b0;
      rx_data  = 8'h00;
   end
   task automatic send(input logic [7:0] b);
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data  <= b;
   endtask
   task automatic idle();
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_data  <= ~rx_data;
   endtask
endmodule
`default_nettype wire

/* dcp_debug_command_port_bench.sv */
// Purpose: Self-checking bench for the debug command port.
// Assumes: 20 MHz clock; host bytes come from the host model.
// Notes:   Pulses are counted so missing or extra ones show.
`timescale 1ns/10ps
`default_nettype none
module dcp_debug_command_port_bench
   import dcp_pkg::*;
;
   // -------
   // Signals
   // -------
   logic        CLK, RESETN, WR, RD, READ_PROTECT, RX_VALID;
   logic [3:0]  ADDR;
   logic [7:0]  WDATA, RDATA, RX_DATA, STUFF_OPCODE;
   logic        DEBUG_HALT, BREAKPOINT_ENABLE, DEVICE_RESET, STUFF_VALID, EXEC_VALID;
   logic [2:0]  STUFF_FETCH_COUNT, EXEC_LENGTH;
   logic [39:0] EXEC_BYTES, e;
   logic [7:0]  q[$];
   logic [7:0]  op[6] = '{8'h0f, 8'h24, 8'h0b, 8'hc8, 8'he9, 8'h38};
   logic [2:0]  ln[6] = '{3'd1, 3'd3, 3'd2, 3'd4, 3'd5, 3'd3};
   int          bad_count = 0, checked = 0, n_stuff = 0, n_exec = 0, n_rst = 0;

   dcp_debug_command_port uut (.CLK, .RESETN, .ADDR, .WDATA, .WR, .RD, .RDATA, .RX_VALID, .RX_DATA,
      .READ_PROTECT, .DEBUG_HALT, .BREAKPOINT_ENABLE, .DEVICE_RESET, .STUFF_VALID, .STUFF_OPCODE,
      .STUFF_FETCH_COUNT, .EXEC_VALID, .EXEC_LENGTH, .EXEC_BYTES);
   dcp_host host (.clk(CLK), .rx_valid(RX_VALID), .rx_data(RX_DATA));

   initial begin
      CLK = 1'b0;
      forever #25 CLK = ~CLK;
   end
   always @(posedge CLK) begin
      n_stuff <= n_stuff + (STUFF_VALID === 1'b1);
      n_exec  <= n_exec + (EXEC_VALID === 1'b1);
      n_rst   <= n_rst + (DEVICE_RESET === 1'b1);
   end
   initial begin
      repeat (2000) @(posedge CLK);
      bad_count++;
      results();
   end

   // -----
   // Tasks
   // -----
   task automatic check(input string name, input logic [47:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge CLK);
      ADDR  <= a;
      WDATA <= d;
      WR    <= 1'b1;
      @(posedge CLK);
      WR    <= 1'b0;
      @(negedge CLK);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge CLK);
      ADDR <= a;
      RD   <= 1'b1;
      @(posedge CLK);
      RD   <= 1'b0;
      @(negedge CLK);
      check("rdata", RDATA, exp);
   endtask
   // Whole frame back to back, then room for the result pulse
   task automatic stream(input logic [7:0] b[$]);
      foreach (b[i]) host.send(b[i]);
      host.idle();
      repeat (2) @(negedge CLK);
   endtask
   task automatic results();
      if (bad_count == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      {RESETN, WR, RD, READ_PROTECT, ADDR, WDATA} = '0;
      repeat (5) @(posedge CLK);
      RESETN <= 1'b1;
      rd(DCP_OFS_CONTROL, DCP_CONTROL_RST);
      rd(4'hf, DCP_RDATA_NONE);
      stream('{DCP_CMD_STUFF, 8'h24});
      check("stuff idle", n_stuff, 0);
      wr(DCP_OFS_CONTROL, DCP_CTL_RESET_STOP);
      check("stop", {DEBUG_HALT, DEVICE_RESET}, 2'b11);
      rd(DCP_OFS_CONTROL, 8'h80);
      // A lone execute code leaves a command open; reset must drop it
      host.send(DCP_CMD_EXECUTE);
      host.idle();
      rd(DCP_OFS_STATUS, 8'h81);
      wr(DCP_OFS_CONTROL, DCP_CTL_RESET_STOP);
      rd(DCP_OFS_STATUS, 8'h80);
      foreach (op[i]) begin
         stream('{DCP_CMD_STUFF, op[i]});
         check("stuff", {n_stuff[2:0], STUFF_FETCH_COUNT, STUFF_OPCODE}, {3'(i + 1), ln[i] - 3'd1, op[i]});
      end
      foreach (op[i]) begin
         q = '{DCP_CMD_EXECUTE, op[i]};
         e = {32'h0, op[i]};
         for (int k = 1; k < ln[i]; k++) begin
            q.push_back(8'ha0 + 8'(k));
            e[8*k +: 8] = 8'ha0 + 8'(k);
         end
         stream(q);
         check("exec", {n_exec[2:0], EXEC_LENGTH, EXEC_BYTES}, {3'(i + 1), ln[i], e});
      end
      @(posedge CLK);
      READ_PROTECT <= 1'b1;
      rd(DCP_OFS_STATUS, 8'h82);
      stream('{DCP_CMD_STUFF, 8'h24, DCP_CMD_EXECUTE, 8'h04});
      @(posedge CLK);
      READ_PROTECT <= 1'b0;
      stream('{DCP_CMD_STUFF, 8'h0f});
      check("protect", {n_stuff[7:0], n_exec[7:0]}, 16'h0706);
      wr(DCP_OFS_CONTROL, DCP_CTL_RUN);
      check("run", {DEBUG_HALT, BREAKPOINT_ENABLE, DEVICE_RESET}, 3'b010);
      stream('{DCP_CMD_EXECUTE, 8'h0f, DCP_CMD_STUFF, 8'h24});
      check("running", {n_stuff[7:0], n_exec[7:0]}, 16'h0706);
      wr(DCP_OFS_CONTROL, DCP_CTL_RESET_GO);
      check("go", {DEBUG_HALT, BREAKPOINT_ENABLE, DEVICE_RESET}, 3'b011);
      @(negedge CLK);
      check("resets", n_rst, 3);
      results();
   end
endmodule
`default_nettype wire
